/* video_dac_defs.svh */
// Constants for the video DAC input register and control block
`ifndef VIDEO_DAC_DEFS_SVH
`define VIDEO_DAC_DEFS_SVH

`define DATA_W 8
`define NIB_W 4
`define THERM_W 15
`define FIFO_DEPTH 8
`define LEVEL_W 4
`define ADDR_W 12
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_CODE 12'h008
`define CTRL_BYPASS_BIT 0
`define STAT_LEVEL_LSB 0
`define STAT_UNDERRUN_BIT 8
`define STAT_BYPASS_BIT 9
`define CTRL_LANE 0
`define STAT_LANE 1
`define FULL_SCALE 8'hFF
`define ZERO_DATA 8'h00
`define ZERO_WORD 32'h0000_0000

`endif

/* video_dac_pkg.sv */
// Types shared by the video DAC control block
`include "video_dac_defs.svh"
package video_dac_pkg;

  // One pixel with its video controls, as queued and captured together
  typedef struct packed {
    logic sync;
    logic blank;
    logic force_to_white;
    logic brighten;
    logic [`DATA_W-1:0] data;
  } pix_s;

  // Switch enables for the weighted current sinks
  typedef struct packed {
    logic sync_en;
    logic blank_en;
    logic bright_en;
    logic [`THERM_W-1:0] msb;
    logic [`NIB_W-1:0] lsb;
  } sink_s;

  // Control state of the top module
  typedef struct packed {
    logic convert_clock_prev;
    logic bypass_sw;
    logic underrun;
    logic [31:0] rdata;
    logic slverr;
  } ctrl_s;

endpackage

/* video_dac_ctrl.sv */
// Pixel FIFO and video DAC input register with control priority logic
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "video_dac_defs.svh"

module pixel_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  // Write side, from the pixel source
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Read side, towards the input register
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } fifo_state_s;

  fifo_state_s state_reg;
  fifo_state_s state_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;
  logic full;
  logic empty;

  // Pointer step with wrap, used by both ends
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(DEPTH-1)) ? '0 : p + AW'(1);
  endfunction

  // Full and empty come from the count, since equal pointers could mean either
  assign full = (state_reg.count == CW'(DEPTH));
  assign empty = (state_reg.count == '0);
  // Honest flags: ready drops when full, valid only when something stored
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[state_reg.rd_ptr];
  assign level = state_reg.count;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer and count update
  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.wr_ptr = step(state_reg.wr_ptr);
    end
    if (pop) begin
      state_next.rd_ptr = step(state_reg.rd_ptr);
    end
    // Count moves only when one end is active; both at once leave it as is
    case ({push, pop})
      2'b10: begin
        state_next.count = state_reg.count + CW'(1);
      end
      2'b01: begin
        state_next.count = state_reg.count - CW'(1);
      end
      default: begin
        state_next.count = state_reg.count;
      end
    endcase
  end

  // Pointers and count clear on reset; the stored words do not
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Storage carries no reset; contents matter only while counted
  // Keeping the array out of the reset tree lets it map onto plain memory
  always_ff @(posedge clk) begin
    if (push) begin
      mem[state_reg.wr_ptr] <= in_data;
    end
  end
endmodule

module video_dac_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pixel source and convert clock
  input wire logic convert_clock,
  input wire logic register_bypass,
  input wire logic [`DATA_W-1:0] pix_data,
  input wire logic pix_sync,
  input wire logic pix_blank,
  input wire logic pix_force_to_white,
  input wire logic pix_brighten,
  input wire logic pix_valid,
  output logic pix_ready,
  // Current sink switches
  output logic [`THERM_W-1:0] sink_msb,
  output logic [`NIB_W-1:0] sink_lsb,
  output logic sink_sync,
  output logic sink_blank,
  output logic sink_bright
);
  // Control state, capture register and decoded words
  video_dac_pkg::ctrl_s state_reg;
  video_dac_pkg::ctrl_s state_next;
  video_dac_pkg::sink_s cap_reg;
  video_dac_pkg::sink_s cap_next;
  video_dac_pkg::sink_s head_dec;
  video_dac_pkg::sink_s out_sel;
  video_dac_pkg::pix_s in_word;
  video_dac_pkg::pix_s head_word;
  // Queue head handshake
  logic head_valid;
  logic head_pop;
  logic [`LEVEL_W-1:0] fifo_level;
  // Mode and convert clock detection
  logic bypass;
  logic convert_clock_edge;
  logic capture;
  logic starve;
  // Register bus phases and write strobes
  logic setup_phase;
  logic wr_access;
  logic wr_ctrl;
  logic clr_underrun;

  // Upper nibble drives fifteen equal segment sinks
  function automatic logic [`THERM_W-1:0] therm(input logic [`NIB_W-1:0] upper);
    therm = '0;
    for (int i = 0; i < `THERM_W; i++) begin
      therm[i] = (upper > `NIB_W'(i));
    end
  endfunction

  // Reference white replaces the data word with full scale
  function automatic logic [`DATA_W-1:0] white_data(input video_dac_pkg::pix_s w);
    white_data = w.force_to_white ? `FULL_SCALE : w.data;
  endfunction

  // Control priority: sync over blank over white and brighten
  function automatic video_dac_pkg::sink_s decode(input video_dac_pkg::pix_s w);
    logic [`DATA_W-1:0] d;
    d = white_data(w);
    decode = '0;
    if (w.sync) begin
      decode.sync_en = 1'b1;
    end else if (w.blank) begin
      decode.blank_en = 1'b1;
    end else begin
      decode.bright_en = w.brighten;
      decode.msb = therm(d[`DATA_W-1:`NIB_W]);
      decode.lsb = d[`NIB_W-1:0];
    end
  endfunction

  // Unused pins tied low by the integrator decode as inactive
  assign in_word = '{sync: pix_sync, blank: pix_blank, force_to_white: pix_force_to_white,
                     brighten: pix_brighten, data: pix_data};

  // Pixel queue between the source and the input register
  pixel_fifo #(
    .WIDTH($bits(video_dac_pkg::pix_s)),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(pix_valid),
    .in_ready(pix_ready),
    .in_data(in_word),
    .out_valid(head_valid),
    .out_ready(head_pop),
    .out_data(head_word),
    .level(fifo_level)
  );

  // Mode select is a plain level, no clock edge involved
  // The pin reaches the sinks through gates only, so a change shows in the same cycle
  assign bypass = register_bypass | state_reg.bypass_sw;
  // Rising convert clock: high now, low at the previous pclk edge
  assign convert_clock_edge = convert_clock & ~state_reg.convert_clock_prev;
  // An empty queue decodes as an all-zero word, the level of unconnected pins
  assign head_dec = decode(head_valid ? head_word : '0);

  // Pop, capture and starvation decisions for this cycle
  // In bypass the queue drains freely so it never blocks the source
  always_comb begin
    capture = 1'b0;
    starve = 1'b0;
    head_pop = 1'b0;
    if (bypass) begin
      head_pop = head_valid;
    end else if (convert_clock_edge) begin
      capture = head_valid;
      starve = ~head_valid;
      head_pop = head_valid;
    end
  end

  // Output follows the queue head directly in bypass, else the register
  assign out_sel = bypass ? head_dec : cap_reg;
  assign sink_msb = out_sel.msb;
  assign sink_lsb = out_sel.lsb;
  assign sink_sync = out_sel.sync_en;
  assign sink_blank = out_sel.blank_en;
  assign sink_bright = out_sel.bright_en;

  // Data and controls land in one register on the same edge
  assign cap_next = capture ? head_dec : cap_reg;

  // Register has no reset: undefined until the first capture
  // A missing first pixel then shows as unknown sinks instead of a false black level
  always_ff @(posedge pclk) begin
    cap_reg <= cap_next;
  end

  // Address match for one register word
  function automatic logic reg_hit(input logic [`ADDR_W-1:0] addr, input logic [`ADDR_W-1:0] offset);
    reg_hit = (addr == offset);
  endfunction

  // True for the three mapped words; every other word answers with an error
  function automatic logic reg_mapped(input logic [`ADDR_W-1:0] addr);
    reg_mapped = reg_hit(addr, `ADDR_CTRL) | reg_hit(addr, `ADDR_STATUS) | reg_hit(addr, `ADDR_CODE);
  endfunction

  // Read value of one word; unused bits and unmapped words read as zero
  function automatic logic [31:0] read_word(
    input logic [`ADDR_W-1:0] addr,
    input logic bypass_sw,
    input logic underrun,
    input logic bypass_now,
    input logic [`LEVEL_W-1:0] level,
    input video_dac_pkg::sink_s code
  );
    read_word = `ZERO_WORD;
    if (reg_hit(addr, `ADDR_CTRL)) begin
      read_word[`CTRL_BYPASS_BIT] = bypass_sw;
    end
    if (reg_hit(addr, `ADDR_STATUS)) begin
      read_word[`STAT_LEVEL_LSB +: `LEVEL_W] = level;
      read_word[`STAT_UNDERRUN_BIT] = underrun;
      read_word[`STAT_BYPASS_BIT] = bypass_now;
    end
    if (reg_hit(addr, `ADDR_CODE)) begin
      read_word[$bits(video_dac_pkg::sink_s)-1:0] = code;
    end
  endfunction

  // APB: read data is prepared in setup so the access needs no wait state
  assign setup_phase = psel & ~penable;
  assign wr_access = psel & penable & pwrite;
  assign pready = penable;
  assign prdata = state_reg.rdata;
  assign pslverr = state_reg.slverr;

  // Write strobes; a byte lane that is off leaves its field untouched
  assign wr_ctrl = wr_access & reg_hit(paddr, `ADDR_CTRL) & pstrb[`CTRL_LANE];
  assign clr_underrun = wr_access & reg_hit(paddr, `ADDR_STATUS) & pstrb[`STAT_LANE] & pwdata[`STAT_UNDERRUN_BIT];

  // Software bypass, underrun flag and the read holding word
  always_comb begin
    state_next = state_reg;
    state_next.convert_clock_prev = convert_clock;
    if (wr_ctrl) begin
      state_next.bypass_sw = pwdata[`CTRL_BYPASS_BIT];
    end
    // Starvation flag: a new event wins over a clear in the same cycle
    if (clr_underrun) begin
      state_next.underrun = 1'b0;
    end
    if (starve) begin
      state_next.underrun = 1'b1;
    end
    // Response is latched at setup and stands until the next setup cycle
    if (setup_phase) begin
      state_next.rdata = read_word(paddr, state_reg.bypass_sw, state_reg.underrun, bypass, fifo_level, out_sel);
      state_next.slverr = ~reg_mapped(paddr);
    end
  end

  // Control state clears on reset; the capture register above does not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule

/* video_dac_monitor.sv */
// Port checker for the video DAC control block
`timescale 1ns/1ps
`include "video_dac_defs.svh"
module video_dac_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic convert_clock,
  input wire logic register_bypass,
  input wire logic pix_valid,
  input wire logic [`THERM_W-1:0] sink_msb,
  input wire logic [`NIB_W-1:0] sink_lsb,
  input wire logic sink_sync,
  input wire logic sink_blank,
  input wire logic sink_bright
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] idle_cnt = 4'h0;
  logic cap_seen = 1'h0;
  wire [21:0] snk = {sink_sync, sink_blank, sink_bright, sink_msb, sink_lsb};
  // Nine idle bypass cycles drain the queue; the capture register is unknown until its first load
  always_ff @(posedge pclk) begin
    if (!register_bypass || pix_valid) begin
      idle_cnt <= 4'h0;
    end else if (idle_cnt != 4'hF) begin
      idle_cnt <= idle_cnt + 4'h1;
    end
    if (!register_bypass && convert_clock && !$past(convert_clock)) cap_seen <= 1'h1;
  end
  a_sync_alone: assert property (sink_sync |-> snk == 22'h20_0000)
    else $error("sync sink not alone");
  a_blank_alone: assert property (sink_blank |-> snk == 22'h10_0000)
    else $error("blank sink not alone");
  a_msb_therm: assert property (sink_msb != 15'h0 |-> (sink_msb & (sink_msb + 15'h1)) == 15'h0)
    else $error("upper sinks not a thermometer");
  a_empty_zero: assert property (idle_cnt >= 4'h9 |-> snk == 22'h0)
    else $error("empty bypass not zero");
  a_hold_edge: assert property (cap_seen && !register_bypass && !(convert_clock && !$past(convert_clock))
    |=> register_bypass || $stable(snk))
    else $error("sinks moved without convert edge");
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("access not ready");
  a_err_unmapped: assert property (psel && !penable && paddr > 12'h008 |=> pslverr && pready)
    else $error("unmapped access without error");
  a_err_mapped: assert property (psel && !penable && paddr == 12'h004 |=> !pslverr)
    else $error("mapped access flagged");
  c_capture: cover property (!register_bypass && convert_clock && !$past(convert_clock));
  c_sync: cover property (sink_sync);
  c_bypass_idle: cover property (idle_cnt >= 4'h9);
endmodule
bind video_dac_ctrl video_dac_monitor video_dac_monitor_inst (.*);

/* pixel_source.sv */
// Pixel source model: offers words and makes convert pulses
`timescale 1ns/1ps
module pixel_source (
  input wire logic pclk,
  input wire logic pix_ready,
  output logic pix_valid,
  output logic [11:0] word,
  output logic convert_clock
);
  initial begin
    pix_valid = 1'h0;
    word = 12'h000;
    convert_clock = 1'h0;
  end
  // Hold word until taken; released pins fall to their pulled-down level
  task automatic offer(input logic [11:0] w);
    @(posedge pclk);
    pix_valid <= 1'h1;
    word <= w;
    do @(posedge pclk); while (pix_ready !== 1'h1);
    pix_valid <= 1'h0;
    word <= 12'h000;
  endtask
  // One convert pulse; clock stays low between pixels
  task automatic convert;
    @(posedge pclk);
    convert_clock <= 1'h1;
    @(posedge pclk);
    convert_clock <= 1'h0;
  endtask
endmodule

/* tb_video_dac_ctrl.sv */
// Self-checking bench for the video DAC control block
`timescale 1ns/1ps
module tb_video_dac_ctrl;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic register_bypass = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata, rd;
  logic pready, pslverr, pix_ready, pix_valid, convert_clock, sink_sync, sink_blank, sink_bright;
  logic [11:0] word;
  logic [14:0] sink_msb;
  logic [3:0] sink_lsb;
  logic [11:0] tbl [8] = '{12'hFFF, 12'h7A5, 12'h300, 12'h200, 12'h000, 12'h15A, 12'h010, 12'h0FF};
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  wire [31:0] sinks = {10'h0, sink_sync, sink_blank, sink_bright, sink_msb, sink_lsb};
  always #2.5 pclk = ~pclk;
  video_dac_ctrl video_dac_ctrl_inst (.*, .pix_data(word[7:0]), .pix_sync(word[11]), .pix_blank(word[10]),
    .pix_force_to_white(word[9]), .pix_brighten(word[8]));
  pixel_source pixel_source_inst (.*);
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for pready rather than assuming zero wait states
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Expected sink word worked out from the control priorities
  function automatic logic [31:0] code(input logic [11:0] w);
    logic [7:0] d;
    d = w[9] ? 8'hFF : w[7:0];
    code = {12'h0, w[8], 15'h0, d[3:0]};
    for (int i = 0; i < 15; i++) code[4 + i] = (d[7:4] > i);
    if (w[10]) code = 32'h10_0000;
    if (w[11]) code = 32'h20_0000;
  endfunction
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 12'h000, 32'h0);
    check(rd, 32'h0);
    apb(1'h0, 12'h004, 32'h0);
    check(rd, 32'h200);
    check(sinks, 32'h0);
    apb(1'h1, 12'h00C, 32'h1);
    check({31'h0, pslverr}, 32'h1);
    apb(1'h1, 12'h000, 32'h1);
    apb(1'h0, 12'h000, 32'h0);
    check(rd, 32'h1);
    apb(1'h1, 12'h000, 32'h0);
    @(posedge pclk) register_bypass <= 1'h0;
    // Sync, blank, white, brighten and plain data cases, each captured with its own pixel
    for (int i = 0; i < 8; i++) begin
      pixel_source_inst.offer(tbl[i]);
      pixel_source_inst.convert();
      #1 check(sinks, code(tbl[i]));
    end
    apb(1'h0, 12'h008, 32'h0);
    check(rd & 32'hF, 32'hF);
    // Fill the queue until it refuses, then drain in order
    for (int i = 0; i < 8; i++) pixel_source_inst.offer({4'h1, 8'(i * 33)});
    #1 check({31'h0, pix_ready}, 32'h0);
    apb(1'h0, 12'h004, 32'h0);
    check(rd & 32'hF, 32'h8);
    for (int i = 0; i < 8; i++) begin
      pixel_source_inst.convert();
      #1 check(sinks, code({4'h1, 8'(i * 33)}));
    end
    @(posedge pclk) presetn <= 1'h0;
    @(posedge pclk) presetn <= 1'h1;
    #1 check(sinks, code(12'h1E7));
    pixel_source_inst.convert();
    #1 check(sinks, code(12'h1E7));
    apb(1'h0, 12'h004, 32'h0);
    check(rd, 32'h100);
    apb(1'h1, 12'h004, 32'h100);
    apb(1'h0, 12'h004, 32'h0);
    check(rd, 32'h0);
    // Bypass switches at once and follows the input word
    @(posedge pclk) register_bypass <= 1'h1;
    #1 check(sinks, 32'h0);
    pixel_source_inst.offer(12'h300);
    #1 check(sinks, code(12'h300));
    @(posedge pclk) register_bypass <= 1'h0;
    #1 check(sinks, code(12'h1E7));
    close_out();
  end
endmodule
